// >>> rtl/conv_ctrl_pkg.sv
// Shared constants for the converter channel and conversion control block.
// Assumes a 32-bit APB register bus with word-aligned registers.
package conv_ctrl_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus geometry
  localparam int          ADDR_W          = 12;
  localparam int          DATA_W          = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [9:0]  IDX_CTRL_A      = 10'h07A;
  localparam logic [9:0]  IDX_INPUT_SEL   = 10'h07C;
  localparam logic [9:0]  IDX_TRIG_SEL    = 10'h07D;
  localparam logic [9:0]  IDX_IRQ_STATUS  = 10'h080;
  localparam logic [9:0]  IDX_IRQ_MASK    = 10'h081;
  localparam logic [ADDR_W-1:0] ADDR_CTRL_A     = {IDX_CTRL_A, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_INPUT_SEL  = {IDX_INPUT_SEL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_TRIG_SEL   = {IDX_TRIG_SEL, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK   = {IDX_IRQ_MASK, 2'b00};

  ////////////////////////////////////////////////////////////////////////////
  // Control register A field positions and reset value
  localparam int          BIT_POWER_ON    = 7;
  localparam int          BIT_GO          = 6;
  localparam int          BIT_AUTO_TRIG   = 5;
  localparam int          BIT_DONE_FLAG   = 4;
  localparam int          BIT_IRQ_ENABLE  = 3;
  localparam int          DIV_LSB         = 0;
  localparam int          DIV_W           = 3;
  localparam logic [7:0]  CTRL_A_RESET    = 8'h00;

  // Input selection, trigger selection and interrupt registers
  localparam int          SEL_W           = 5;
  localparam logic [4:0]  SEL_RESET       = 5'h00;
  localparam logic [4:0]  SEL_BANDGAP     = 5'h1E;
  localparam logic [4:0]  SEL_GROUND      = 5'h1F;
  localparam int          TRIG_W          = 3;
  localparam logic [2:0]  TRIG_RESET      = 3'h0;
  localparam logic [2:0]  TRIG_FREE_RUN   = 3'h0;
  localparam int          IRQ_W           = 2;
  localparam int          IRQ_BIT_DONE    = 0;
  localparam int          IRQ_BIT_ABORT   = 1;
  localparam logic [1:0]  IRQ_RESET       = 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // Gain encoding driven to the analog core
  localparam logic [1:0]  GAIN_1X         = 2'h0;
  localparam logic [1:0]  GAIN_10X        = 2'h1;
  localparam logic [1:0]  GAIN_200X       = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion lengths in converter clock cycles, and prescaler
  localparam int          CNT_W           = 5;
  localparam logic [4:0]  CONV_LEN_FIRST  = 5'h19;
  localparam logic [4:0]  CONV_LEN_NORMAL = 5'h0D;
  localparam int          DIV_CNT_W       = 8;
  localparam logic [2:0]  DIV_CODE_MIN    = 3'h1;
  localparam logic [7:0]  DIV_MIN         = 8'h02;

endpackage : conv_ctrl_pkg

// >>> rtl/conv_clock_divider.sv
// Prescaler that turns the system clock into converter clock ticks.
// Assumes run is low between conversions so each conversion starts phase aligned.
`timescale 1ns/1ps
module conv_clock_divider
  import conv_ctrl_pkg::*;
(
  input  wire logic             ref_clk,
  input  wire logic             rst_b,
  input  wire logic             run,
  input  wire logic [DIV_W-1:0] divider_code,
  output logic                  tick
);

  logic [DIV_CNT_W-1:0] count_reg;
  logic [DIV_CNT_W-1:0] count_next;
  wire  [DIV_CNT_W-1:0] divisor;
  wire  [DIV_CNT_W-1:0] last_count;

  ////////////////////////////////////////////////////////////////////////////
  // Codes 0 and 1 divide by two, each higher code doubles
  assign divisor    = (divider_code <= DIV_CODE_MIN) ? DIV_MIN   // RULE_16
                                                     : (8'h01 << divider_code);
  assign last_count = divisor - 8'h01;
  assign tick       = run && (count_reg == last_count);
  assign count_next = (!run || tick) ? '0 : count_reg + 8'h01;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  AST_DIV_PERIOD: assert property ( // RULE_16
    tick ##1 run |-> !tick && (count_reg == 8'h00)
  ) else $error("Prescaler tick spacing wrong");

endmodule : conv_clock_divider

// >>> rtl/adc_channel_and_conversion_control.sv
// Channel, gain and conversion control for an on-chip analog converter.
// Assumes an APB master on the register side and an analog core that samples
// on conv_start and steps on conv_tick; trigger events are synchronous levels.
//
// Notes on behaviour
// RULE_01: Five-bit select field picks input or pair and differential gain.
// RULE_02: Select changes during a conversion apply only after it completes.
// RULE_03: Codes 0-7 single-ended inputs; 0x1E bandgap; 0x1F ground.
// RULE_04: Codes 8-15 pairs against negative 0 or 2; gain 10x or 200x.
// RULE_05: Codes 16-23 against negative 1, 24-29 against negative 2, unity.
// RULE_06: Control bit 7 powers the converter on, zero shuts it off.
// RULE_07: Clearing power during a conversion aborts it at once.
// RULE_08: Single mode: each write of one to bit 6 starts one conversion.
// RULE_09: Free running: one go write starts, then it keeps converting.
// RULE_10: First conversion after power on lasts 25 ticks, later ones 13.
// RULE_11: Go bit reads one while converting, clears itself on completion.
// RULE_12: Writing zero to the go bit has no effect.
// RULE_13: With auto trigger on, rising edge of chosen trigger starts one.
// RULE_14: Control A holds power, go, auto, done, irq enable, divider; resets zero.
// RULE_15: Done flag sets on completion; cleared by vector or writing one.
// RULE_16: Divider codes 0,1 give 2, each next code doubles up to 128.
// RULE_17: Trigger source zero means completion re-triggers a conversion.
// RULE_18: Auto-triggered conversions also show the go bit as one.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module adc_channel_and_conversion_control
  import conv_ctrl_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic                   pready,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pslverr,
  input  wire logic [7:0]        trigger_events,
  input  wire logic              irq_ack,
  output logic                   irq,
  output logic                   converter_power_on,
  output logic                   conv_start,
  output logic                   conv_tick,
  output logic                   conv_active,
  output logic                   conv_complete,
  output logic                   conv_init,
  output logic                   sel_single_ended,
  output logic                   sel_differential,
  output logic                   sel_bandgap,
  output logic                   sel_ground,
  output logic [2:0]             pos_input,
  output logic [2:0]             neg_input,
  output logic [1:0]             gain_code
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic             power_on_reg;
  logic             auto_trigger_on_reg;
  logic             done_flag_reg;
  logic             irq_enable_reg;
  logic [DIV_W-1:0] divider_reg;
  logic [SEL_W-1:0] input_gain_select_reg;
  logic [TRIG_W-1:0] trigger_source_select_reg;
  logic [IRQ_W-1:0] irq_status_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic             busy_reg;
  logic             init_needed_reg;
  logic [CNT_W-1:0] remaining_reg;
  logic [CNT_W-1:0] conv_len_reg;
  logic             trig_prev_reg;
  logic             start_pulse_reg;
  logic             complete_pulse_reg;
  logic [SEL_W-1:0] applied_sel_reg;
  logic             single_reg;
  logic             diff_reg;
  logic             bandgap_reg;
  logic             ground_reg;
  logic [2:0]       pos_reg;
  logic [2:0]       neg_reg;
  logic [1:0]       gain_reg;
  logic [DATA_W-1:0] prdata_reg;
  logic             pslverr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode
  wire wr_en       = psel && penable && pwrite;
  wire hit_ctrl    = (paddr == ADDR_CTRL_A);
  wire hit_sel     = (paddr == ADDR_INPUT_SEL);
  wire hit_trig    = (paddr == ADDR_TRIG_SEL);
  wire hit_status  = (paddr == ADDR_IRQ_STATUS);
  wire hit_mask    = (paddr == ADDR_IRQ_MASK);
  wire hit_any     = hit_ctrl || hit_sel || hit_trig || hit_status || hit_mask;
  wire wr_ctrl     = wr_en && hit_ctrl;
  wire wr_sel      = wr_en && hit_sel;
  wire wr_trig     = wr_en && hit_trig;
  wire wr_status   = wr_en && hit_status;
  wire wr_mask     = wr_en && hit_mask;
  wire setup_phase = psel && !penable;

  ////////////////////////////////////////////////////////////////////////////
  // Conversion control
  wire power_next  = wr_ctrl ? pwdata[BIT_POWER_ON] : power_on_reg;          // RULE_06
  wire disable_wr  = wr_ctrl && !pwdata[BIT_POWER_ON];
  wire sw_go       = wr_ctrl && pwdata[BIT_GO];                              // RULE_08 RULE_12
  wire free_run    = auto_trigger_on_reg && (trigger_source_select_reg == TRIG_FREE_RUN);
  wire trig_level  = (trigger_source_select_reg != TRIG_FREE_RUN)
                     && trigger_events[trigger_source_select_reg];
  wire trig_edge   = trig_level && !trig_prev_reg;
  wire tick;
  wire finishing   = busy_reg && tick && (remaining_reg == 5'h01);
  wire start_cause = sw_go                                                   // RULE_08 RULE_09
                     || (auto_trigger_on_reg && trig_edge)                   // RULE_13
                     || (finishing && free_run);                             // RULE_17
  wire start_evt   = power_next && start_cause && (!busy_reg || finishing);
  wire busy_next   = start_evt ? 1'b1                                        // RULE_18
                   : (finishing || disable_wr) ? 1'b0 : busy_reg;            // RULE_07 RULE_11
  wire [CNT_W-1:0] len_sel = init_needed_reg ? CONV_LEN_FIRST              // RULE_10
                                             : CONV_LEN_NORMAL;
  wire [CNT_W-1:0] remaining_next = start_evt ? len_sel
                                  : (busy_reg && tick) ? remaining_reg - 5'h01
                                  : remaining_reg;
  wire init_next   = !power_next ? 1'b1 : start_evt ? 1'b0 : init_needed_reg;
  wire done_clear  = (wr_ctrl && pwdata[BIT_DONE_FLAG]) || irq_ack;
  wire done_next   = finishing || (done_flag_reg && !done_clear);            // RULE_15
  wire aborting    = disable_wr && busy_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt status, set wins over write-one-to-clear
  wire [IRQ_W-1:0] irq_events = {aborting, finishing};
  wire [IRQ_W-1:0] irq_status_next =
      irq_events | (irq_status_reg & ~(wr_status ? pwdata[IRQ_W-1:0] : 2'b00));
  assign irq = (done_flag_reg && irq_enable_reg) || |(irq_status_reg & irq_mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Selection decode from the applied code
  wire [SEL_W-1:0] sel_src  = (busy_reg && !finishing) ? applied_sel_reg        // RULE_02
                                                      : input_gain_select_reg;
  wire             d_bg     = (sel_src == SEL_BANDGAP);                       // RULE_03
  wire             d_gnd    = (sel_src == SEL_GROUND);
  wire             d_single = (sel_src[4:3] == 2'b00);
  wire             d_pairlo = (sel_src[4:3] == 2'b01);                        // RULE_04
  wire             d_diff   = !d_single && !d_bg && !d_gnd;
  wire [2:0]       d_pos    = d_pairlo ? {1'b0, sel_src[2], sel_src[0]} : sel_src[2:0];
  wire [2:0]       d_neg    = d_pairlo ? {1'b0, sel_src[2], 1'b0}             // RULE_04
                            : (sel_src[4:3] == 2'b10) ? 3'h1                 // RULE_05
                            : (sel_src[4:3] == 2'b11) ? 3'h2 : 3'h0;
  wire [1:0]       d_gain   = d_pairlo ? (sel_src[1] ? GAIN_200X : GAIN_10X) : GAIN_1X;

  ////////////////////////////////////////////////////////////////////////////
  // Register read mux
  wire [7:0] ctrl_a_view = {power_on_reg, busy_reg, auto_trigger_on_reg,     // RULE_14
                            done_flag_reg, irq_enable_reg, divider_reg};     // RULE_11
  wire [DATA_W-1:0] rd_mux =
      hit_ctrl   ? {24'h000000, ctrl_a_view}
    : hit_sel    ? {27'h0000000, input_gain_select_reg}
    : hit_trig   ? {29'h00000000, trigger_source_select_reg}
    : hit_status ? {30'h00000000, irq_status_reg}
    : hit_mask   ? {30'h00000000, irq_mask_reg}
    : 32'h00000000;

  assign pready  = psel && penable;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg && psel && penable;

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler
  conv_clock_divider u_divider (
    .ref_clk      (ref_clk),
    .rst_b        (rst_b),
    .run          (busy_reg),
    .divider_code (divider_reg),
    .tick         (tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      power_on_reg              <= CTRL_A_RESET[BIT_POWER_ON];               // RULE_14
      auto_trigger_on_reg       <= CTRL_A_RESET[BIT_AUTO_TRIG];
      irq_enable_reg            <= CTRL_A_RESET[BIT_IRQ_ENABLE];
      divider_reg               <= CTRL_A_RESET[DIV_W-1:0];
      input_gain_select_reg     <= SEL_RESET;
      trigger_source_select_reg <= TRIG_RESET;
      irq_mask_reg              <= IRQ_RESET;
    end else begin
      power_on_reg <= power_next;
      if (wr_ctrl) begin
        auto_trigger_on_reg <= pwdata[BIT_AUTO_TRIG];
        irq_enable_reg      <= pwdata[BIT_IRQ_ENABLE];
        divider_reg         <= pwdata[DIV_LSB +: DIV_W];
      end
      if (wr_sel) begin
        input_gain_select_reg <= pwdata[SEL_W-1:0];                         // RULE_01
      end
      if (wr_trig) begin
        trigger_source_select_reg <= pwdata[TRIG_W-1:0];
      end
      if (wr_mask) begin
        irq_mask_reg <= pwdata[IRQ_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Conversion sequencing and flags
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      busy_reg           <= 1'b0;
      init_needed_reg    <= 1'b1;
      remaining_reg      <= '0;
      conv_len_reg       <= '0;
      trig_prev_reg      <= 1'b0;
      start_pulse_reg    <= 1'b0;
      complete_pulse_reg <= 1'b0;
      done_flag_reg      <= CTRL_A_RESET[BIT_DONE_FLAG];
      irq_status_reg     <= IRQ_RESET;
    end else begin
      busy_reg           <= busy_next;
      init_needed_reg    <= init_next;
      remaining_reg      <= remaining_next;
      conv_len_reg       <= start_evt ? len_sel : conv_len_reg;
      trig_prev_reg      <= trig_level;
      start_pulse_reg    <= start_evt;
      complete_pulse_reg <= finishing;
      done_flag_reg      <= done_next;
      irq_status_reg     <= irq_status_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Applied selection and decoded outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      applied_sel_reg <= SEL_RESET;
      single_reg      <= 1'b1;
      diff_reg        <= 1'b0;
      bandgap_reg     <= 1'b0;
      ground_reg      <= 1'b0;
      pos_reg         <= 3'h0;
      neg_reg         <= 3'h0;
      gain_reg        <= GAIN_1X;
    end else begin
      applied_sel_reg <= sel_src;                                            // RULE_02
      single_reg      <= d_single;                                           // RULE_03
      diff_reg        <= d_diff;
      bandgap_reg     <= d_bg;
      ground_reg      <= d_gnd;
      pos_reg         <= d_pos;                                              // RULE_05
      neg_reg         <= d_neg;
      gain_reg        <= d_gain;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data captured in the setup phase
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      prdata_reg  <= '0;
      pslverr_reg <= 1'b0;
    end else if (setup_phase) begin
      prdata_reg  <= rd_mux;
      pslverr_reg <= !hit_any;
    end
  end

  assign converter_power_on = power_on_reg;
  assign conv_start         = start_pulse_reg;
  assign conv_tick          = tick;
  assign conv_active        = busy_reg;
  assign conv_complete      = complete_pulse_reg;
  assign conv_init          = busy_reg && (conv_len_reg == CONV_LEN_FIRST);
  assign sel_single_ended   = single_reg;
  assign sel_differential   = diff_reg;
  assign sel_bandgap        = bandgap_reg;
  assign sel_ground         = ground_reg;
  assign pos_input          = pos_reg;
  assign neg_input          = neg_reg;
  assign gain_code          = gain_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic [CNT_W-1:0] ticks_seen_reg;
  always_ff @(posedge ref_clk) begin
    if (!rst_b || start_evt) begin
      ticks_seen_reg <= '0;
    end else if (busy_reg && tick) begin
      ticks_seen_reg <= ticks_seen_reg + 5'h01;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  AST_SEL_HOLD: assert property ( // RULE_02
    busy_reg && !finishing |=> $stable(applied_sel_reg) && $stable(pos_reg) && $stable(neg_reg)
  ) else $error("Selection changed during a conversion");

  AST_DECODE: assert property ( // RULE_03
    (applied_sel_reg == SEL_BANDGAP) |-> bandgap_reg && !ground_reg && !diff_reg
  ) else $error("Bandgap code decoded wrong");

  AST_DIFF_GAIN: assert property ( // RULE_04
    (applied_sel_reg[4:3] == 2'b01) |->
      diff_reg && gain_reg == (applied_sel_reg[1] ? GAIN_200X : GAIN_10X)
      && neg_reg == (applied_sel_reg[2] ? 3'h2 : 3'h0)
  ) else $error("Differential pair or gain decoded wrong");

  AST_UNITY: assert property ( // RULE_05
    applied_sel_reg[4] && !bandgap_reg && !ground_reg |->
      gain_reg == GAIN_1X && pos_reg == applied_sel_reg[2:0]
  ) else $error("Unity gain pair decoded wrong");

  AST_ABORT: assert property ( // RULE_07
    disable_wr && busy_reg |=> !busy_reg && !converter_power_on ##1 !conv_complete
  ) else $error("Disable did not abort the conversion");

  AST_GO_START: assert property ( // RULE_08
    sw_go && power_next && !busy_reg |=> busy_reg ##0 conv_start
  ) else $error("Go write did not start a conversion");

  AST_LENGTH: assert property ( // RULE_10
    finishing |-> (ticks_seen_reg + 5'h01) == conv_len_reg
  ) else $error("Conversion length wrong");

  AST_ZERO_GO: assert property ( // RULE_12
    busy_reg && wr_ctrl && pwdata[BIT_POWER_ON] && !pwdata[BIT_GO] && !finishing |=> busy_reg
  ) else $error("Writing zero to go disturbed a conversion");

  AST_AUTO_START: assert property ( // RULE_13
    auto_trigger_on_reg && trig_edge && power_next && !busy_reg |=> busy_reg
  ) else $error("Trigger edge did not start a conversion");

  AST_DONE_FLAG: assert property ( // RULE_15
    finishing |=> done_flag_reg && !busy_reg [*1] or conv_start
  ) else $error("Done flag not set on completion");

  AST_FREE_RUN: assert property ( // RULE_17
    finishing && free_run && power_next |=> busy_reg && conv_start
  ) else $error("Free running did not restart");

  COV_FIRST: cover property (finishing && conv_len_reg == CONV_LEN_FIRST);
  COV_FREE: cover property (finishing && free_run ##1 busy_reg);
  COV_ABORT: cover property (aborting);
  COV_AUTO: cover property (auto_trigger_on_reg && trig_edge && start_evt);

endmodule : adc_channel_and_conversion_control

// >>> verification/analog_core_model.sv
// Stand-in for the analog core: latches the routing at each start and counts ticks.
// Assumes start, tick and complete pulses come from the control block on one clock.
`timescale 1ns/1ps
module analog_core_model (
  input  wire logic       ref_clk,
  input  wire logic       conv_start,
  input  wire logic       conv_tick,
  input  wire logic       conv_active,
  input  wire logic       conv_complete,
  input  wire logic [7:0] route,
  output logic      [7:0] held_route,
  output logic      [7:0] ticks_seen
);
  logic [7:0] tick_cnt;
  always_ff @(posedge ref_clk) begin
    if (conv_start) held_route <= route;
    if (conv_complete) ticks_seen <= tick_cnt;
    if (conv_start) tick_cnt <= 8'h00;
    else if (conv_tick && conv_active) tick_cnt <= tick_cnt + 8'h01;
  end
endmodule : analog_core_model

// >>> verification/tb.sv
// Testbench: APB register access, conversions, triggers, aborts and interrupts.
// Assumes zero-wait APB slave and the analog core stand-in beside the design.
`timescale 1ns/1ps
module tb
  import conv_ctrl_pkg::*;
;
  logic ref_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic irq_ack = 1'b0, err, pready, pslverr, irq, converter_power_on, conv_init;
  logic conv_start, conv_tick, conv_active, conv_complete;
  logic sel_single_ended, sel_differential, sel_bandgap, sel_ground;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0, prdata, rd;
  logic [7:0] trigger_events = 8'h00, held_route, ticks_seen;
  logic [2:0] pos_input, neg_input;
  logic [1:0] gain_code;
  logic [15:0] s = 16'h0010;
  logic [4:0] code_a;
  int n_errors = 0, check_count = 0, cyc = 0, n;
  always #25 ref_clk = ~ref_clk;
  adc_channel_and_conversion_control dut (.ref_clk, .rst_b, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pready, .prdata, .pslverr, .trigger_events, .irq_ack, .irq,
    .converter_power_on, .conv_start, .conv_tick, .conv_active, .conv_complete,
    .conv_init, .sel_single_ended, .sel_differential, .sel_bandgap, .sel_ground,
    .pos_input, .neg_input, .gain_code);
  analog_core_model core (.ref_clk, .conv_start, .conv_tick, .conv_active,
    .conv_complete, .route({pos_input, neg_input, gain_code}), .held_route, .ticks_seen);
  ////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : lfsr
  function automatic logic [11:0] dec(input logic [4:0] c);
    logic [3:0] f;
    logic [2:0] p, q;
    logic [1:0] g;
    f = c < 8 ? 4'h8 : c < 30 ? 4'h4 : c == 30 ? 4'h2 : 4'h1;
    p = c[2:0];
    q = c[4:3] == 2'h2 ? 3'h1 : c[4:3] == 2'h3 ? 3'h2 : 3'h0;
    g = GAIN_1X;
    if (c[4:3] == 2'h1) begin
      p = {1'b0, c[2], c[0]};
      q = c[2] ? 3'h2 : 3'h0;
      g = c[1] ? GAIN_200X : GAIN_10X;
    end
    return c < 30 ? {f, p, q, g} : {f, 8'h00};
  endfunction : dec
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic chkdec(input logic [4:0] c);
    chk({20'h0, sel_single_ended, sel_differential, sel_bandgap, sel_ground,
         c > 29 ? 8'h00 : {pos_input, neg_input, gain_code}}, {20'h0, dec(c)});
  endtask : chkdec
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : bus
  task automatic wcomp();
    do @(negedge ref_clk); while (conv_complete !== 1'b1);
    @(negedge ref_clk);
  endtask : wcomp
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_errors++;
      final_report();
    end
  end
  ////////////////////
  initial begin
    repeat (10) @(posedge ref_clk);
    rst_b <= 1'b1;
    bus(1'b0, ADDR_CTRL_A, 32'h0);
    chk(rd, {24'h0, CTRL_A_RESET});
    bus(1'b0, 12'h100, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int c = 0; c < 32; c++) begin
      bus(1'b1, ADDR_INPUT_SEL, 32'(c));
      repeat (2) @(negedge ref_clk);
      chkdec(c[4:0]);
    end
    s = lfsr(s);
    code_a = {1'b0, s[5:2]};
    bus(1'b1, ADDR_INPUT_SEL, {27'h0, code_a});
    bus(1'b1, ADDR_CTRL_A, 32'hC9);
    bus(1'b1, ADDR_INPUT_SEL, {27'h0, code_a | 5'h10});
    bus(1'b1, ADDR_CTRL_A, 32'h89);
    bus(1'b0, ADDR_CTRL_A, 32'h0);
    @(negedge ref_clk);
    chk(rd[7:6], 2'h3);
    chk(conv_init, 1'b1);
    chkdec(code_a);
    wcomp();
    chk(ticks_seen, 8'd25);
    chk(held_route, dec(code_a) & 12'h0FF);
    chk(irq, 1'b1);
    repeat (2) @(negedge ref_clk);
    chkdec(code_a | 5'h10);
    bus(1'b0, ADDR_CTRL_A, 32'h0);
    chk(rd[7:4], 4'h9);
    @(posedge ref_clk) irq_ack <= 1'b1;
    @(posedge ref_clk) irq_ack <= 1'b0;
    @(negedge ref_clk);
    chk(irq, 1'b0);
    for (int d = 0; d < 8; d++) begin
      bus(1'b1, ADDR_CTRL_A, 32'hC0 | d);
      do @(negedge ref_clk); while (conv_tick !== 1'b1);
      n = 0;
      do begin @(negedge ref_clk); n++; end while (conv_tick !== 1'b1);
      chk(32'(n), 32'(1 << (d < 2 ? 1 : d)));
      wcomp();
      chk(ticks_seen, 8'd13);
      bus(1'b1, ADDR_CTRL_A, 32'h90);
      bus(1'b0, ADDR_CTRL_A, 32'h0);
      chk(rd[6:4], 3'h0);
    end
    bus(1'b1, ADDR_IRQ_MASK, 32'h2);
    bus(1'b1, ADDR_CTRL_A, 32'hC0);
    bus(1'b1, ADDR_CTRL_A, 32'h00);
    repeat (2) @(negedge ref_clk);
    chk({conv_active, converter_power_on, irq}, 3'h1);
    bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
    chk(rd, 32'h3);
    bus(1'b1, ADDR_IRQ_STATUS, 32'h2);
    @(negedge ref_clk);
    chk(irq, 1'b0);
    bus(1'b1, ADDR_TRIG_SEL, 32'h2);
    bus(1'b1, ADDR_CTRL_A, 32'hA0);
    @(posedge ref_clk) trigger_events <= 8'h04;
    repeat (3) @(negedge ref_clk);
    chk(conv_active, 1'b1);
    bus(1'b0, ADDR_CTRL_A, 32'h0);
    chk(rd[6], 1'b1);
    wcomp();
    bus(1'b1, ADDR_TRIG_SEL, 32'h0);
    bus(1'b1, ADDR_CTRL_A, 32'hE0);
    wcomp();
    @(negedge ref_clk);
    chk(conv_active, 1'b1);
    wcomp();
    chk(ticks_seen, 8'd13);
    bus(1'b1, ADDR_CTRL_A, 32'h0);
    final_report();
  end
endmodule : tb
